// file: logic/eit_timer.v
// Eight-bit interval timer with carrier and PWM modes, top level
//
// Functional notes
// - Run bit clear stops, zeroes counter
// - Three-bit field selects count clock source
// - Two-bit field selects interval, carrier, PWM
// - Level bit sets idle output level
// - Output enable passes square wave to pin
// - Remote output from remote and gate bits
// - Read-only gate status flag on bit zero
// - Direction bits: zero output, reset ones
// - Period match interrupts and clears counter
// - Interval mode ignores secondary compare
// - Interval equals period value plus one
// - Counting starts on second count clock after start
// - Period match clears, toggles, interrupts on tick
// - Stop returns outputs to default levels
`timescale 1ns/1ps
module eit_timer (
  input  wire        mclk,
  input  wire        reset_n,
  input  wire        lowSpeedClk,
  input  wire        companionMatch,
  input  wire [15:0] regAddr,
  input  wire [7:0]  regWrData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [7:0]  regRdData,
  output reg         matchInterrupt,
  output reg         timerOutputPin,
  output reg         timerPinOe,
  output reg         remoteOutput,
  output reg  [7:0]  portDirection
);
`include "eit_consts.vh"

  reg  [7:0] modeCtrl_q;       // Mode register
  reg  [7:0] periodCmp_q;      // Period compare
  reg  [7:0] secondCmp_q;      // Secondary compare
  reg  [7:0] count_q;          // Counter
  reg        outLevel_q;       // Output flip-flop, xor with idle level
  reg        cmpSel_q;         // Carrier/PWM: comparing secondary
  reg        remoteCtl_q;      // Remote control bit
  reg        gateReq_q;        // Carrier gate request
  reg        gateStat_q;       // Carrier gate status
  reg        armed_q;          // First tick after start masked
  reg  [2:0] lsSync_q;         // Low-speed clock synchroniser
  reg  [2:0] compSync_q;       // Companion event synchroniser
  reg        lsPrev_q;         // Low-speed clock last level
  reg        compPrev_q;       // Companion event last level
  reg  [1:0] xferDly_q;        // Gate transfer delay
  wire       lsTick;           // Low-speed rising edge pulse
  wire       compEvt;          // Companion event rising edge
  wire       countTick;        // Selected count clock
  wire       run;
  wire [1:0] mode;
  wire       idleLevel;
  wire [7:0] cmpVal;
  wire       useSecond;
  wire       match;
  wire       secMatch;
  wire       periodMatch;
  wire       pinOut;
  wire       pinIsOut;
  wire       outLevelNext;     // Output state as it will be after this edge
  reg        remoteNext;

  assign run       = modeCtrl_q[`EIT_MODE_RUN];
  assign mode      = modeCtrl_q[`EIT_MODE_MD_HI:`EIT_MODE_MD_LO];
  assign idleLevel = modeCtrl_q[`EIT_MODE_LEV];
  // Interval mode never selects secondary compare
  assign useSecond = cmpSel_q && (mode != `EIT_MD_INTERVAL);
  assign cmpVal    = useSecond ? secondCmp_q : periodCmp_q;
  assign match     = run && armed_q && countTick && (count_q == cmpVal);
  assign secMatch  = match && useSecond;
  assign periodMatch = match && !useSecond;
  // Low-speed clock edge once second and third stages agree
  assign lsTick    = (lsSync_q[2] == lsSync_q[1]) && lsSync_q[2] && !lsPrev_q;
  assign compEvt   = (compSync_q[2] == compSync_q[1]) && compSync_q[2]
                     && !compPrev_q;
  // Next output state, so the pin moves on the same edge as the interrupt
  assign outLevelNext = run & (outLevel_q ^ match);
  assign pinOut    = idleLevel ^
                     (outLevelNext & modeCtrl_q[`EIT_MODE_OE]);
  assign pinIsOut  = !portDirection[`EIT_TIMER_PIN];

  // Count clock enable generation
  eit_count_clock uClk (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .lowSpeedTick (lsTick),
    .clockSelect  (modeCtrl_q[`EIT_MODE_CKS_HI:`EIT_MODE_CKS_LO]),
    .countTick    (countTick)
  );

  // Input synchronisers for external signals
  always @(posedge mclk) begin
    if (!reset_n) begin
      lsSync_q   <= 3'h0;
      compSync_q <= 3'h0;
      lsPrev_q   <= 1'b0;
      compPrev_q <= 1'b0;
    end else begin
      lsSync_q   <= {lsSync_q[1:0], lowSpeedClk};
      compSync_q <= {compSync_q[1:0], companionMatch};
      if (lsSync_q[2] == lsSync_q[1]) begin
        lsPrev_q <= lsSync_q[2];
      end
      if (compSync_q[2] == compSync_q[1]) begin
        compPrev_q <= compSync_q[2];
      end
    end
  end

  // Register writes
  always @(posedge mclk) begin
    if (!reset_n) begin
      modeCtrl_q    <= `EIT_RST_MODE;
      periodCmp_q   <= `EIT_RST_CMP;
      secondCmp_q   <= `EIT_RST_CMP;
      remoteCtl_q   <= 1'b0;
      gateReq_q     <= 1'b0;
      portDirection <= `EIT_RST_PORT_DIR;
    end else if (regWrite) begin
      case (regAddr)
        `EIT_ADDR_MODE: begin
          // Only run bit may change while running
          if (run) begin
            modeCtrl_q[`EIT_MODE_RUN] <= regWrData[`EIT_MODE_RUN];
          end else begin
            modeCtrl_q <= regWrData;
          end
        end
        `EIT_ADDR_CARRIER: begin
          remoteCtl_q <= regWrData[`EIT_CAR_REMOTE];
          gateReq_q   <= regWrData[`EIT_CAR_REQ];
        end
        `EIT_ADDR_PORT_DIR: portDirection <= regWrData;
        `EIT_ADDR_PERIOD:   periodCmp_q   <= regWrData;
        `EIT_ADDR_SECONDARY: secondCmp_q  <= regWrData;
        default: ;
      endcase
    end
  end

  // Counter, output flip-flop and interrupt
  always @(posedge mclk) begin
    if (!reset_n) begin
      count_q        <= `EIT_ZERO8;
      outLevel_q     <= 1'b0;
      cmpSel_q       <= 1'b0;
      armed_q        <= 1'b0;
      matchInterrupt <= 1'b0;
    end else if (!run) begin
      // Stopped: counter zero, outputs default
      count_q        <= `EIT_ZERO8;
      outLevel_q     <= 1'b0;
      cmpSel_q       <= 1'b0;
      armed_q        <= 1'b0;
      matchInterrupt <= 1'b0;
    end else begin
      matchInterrupt <= 1'b0;
      if (countTick) begin
        if (!armed_q) begin
          // First count clock after start is masked
          armed_q <= 1'b1;
        end else if (periodMatch) begin
          count_q        <= `EIT_ZERO8;
          outLevel_q     <= !outLevel_q;
          matchInterrupt <= 1'b1;
          if (mode != `EIT_MD_INTERVAL) begin
            cmpSel_q <= 1'b1;
          end
        end else if (secMatch) begin
          // Secondary match toggles only; carrier also clears and interrupts
          outLevel_q <= !outLevel_q;
          cmpSel_q   <= 1'b0;
          if (mode == `EIT_MD_CARRIER) begin
            count_q        <= `EIT_ZERO8;
            matchInterrupt <= 1'b1;
          end else begin
            count_q <= count_q + `EIT_ONE8;
          end
        end else begin
          count_q <= count_q + `EIT_ONE8;
        end
      end
    end
  end

  // Gate status takes request on second count clock after event
  always @(posedge mclk) begin
    if (!reset_n) begin
      xferDly_q  <= 2'h0;
      gateStat_q <= 1'b0;
    end else begin
      if (compEvt) begin
        xferDly_q <= `EIT_XFER_START;
      end else if (countTick && xferDly_q != 2'h0) begin
        if (xferDly_q == `EIT_XFER_LAST) begin
          gateStat_q <= gateReq_q;
          xferDly_q  <= 2'h0;
        end else begin
          xferDly_q <= xferDly_q + 2'h1;
        end
      end
    end
  end

  // Remote output selection
  always @* begin
    case ({remoteCtl_q, gateReq_q})
      2'h1:    remoteNext = 1'b1;
      2'h3:    remoteNext = gateStat_q & pinOut;
      default: remoteNext = 1'b0;
    endcase
  end

  // Registered pin, remote output and read data
  always @(posedge mclk) begin
    if (!reset_n) begin
      timerOutputPin <= 1'b0;
      timerPinOe     <= 1'b0;
      remoteOutput   <= 1'b0;
      regRdData      <= `EIT_ZERO8;
    end else begin
      timerOutputPin <= (mode == `EIT_MD_CARRIER) ? remoteNext : pinOut;
      timerPinOe     <= pinIsOut;
      remoteOutput   <= remoteNext;
      if (regRead) begin
        case (regAddr)
          `EIT_ADDR_MODE:      regRdData <= modeCtrl_q;
          `EIT_ADDR_CARRIER:   regRdData <= {5'h00, remoteCtl_q,
                                             gateReq_q, gateStat_q};
          `EIT_ADDR_PORT_DIR:  regRdData <= portDirection;
          `EIT_ADDR_PERIOD:    regRdData <= periodCmp_q;
          `EIT_ADDR_SECONDARY: regRdData <= secondCmp_q;
          default:             regRdData <= `EIT_ZERO8;
        endcase
      end
    end
  end

endmodule // eit_timer

// file: logic/eit_consts.vh
// Constants for the eight-bit interval timer control block
`ifndef EIT_CONSTS_VH
`define EIT_CONSTS_VH

// Register addresses
`define EIT_ADDR_PORT_DIR    16'hff21
`define EIT_ADDR_MODE        16'hff6c
`define EIT_ADDR_CARRIER     16'hff6d
`define EIT_ADDR_PERIOD      16'hff1a
`define EIT_ADDR_SECONDARY   16'hff1b

// Reset values
`define EIT_RST_PORT_DIR     8'hff
`define EIT_RST_MODE         8'h00
`define EIT_RST_CARRIER      8'h00
`define EIT_RST_CMP          8'h00

// Mode register fields
`define EIT_MODE_RUN         7
`define EIT_MODE_CKS_HI      6
`define EIT_MODE_CKS_LO      4
`define EIT_MODE_MD_HI       3
`define EIT_MODE_MD_LO       2
`define EIT_MODE_LEV         1
`define EIT_MODE_OE          0

// Carrier register fields
`define EIT_CAR_REMOTE       2
`define EIT_CAR_REQ          1
`define EIT_CAR_STAT         0

// Operating modes
`define EIT_MD_INTERVAL      2'h0
`define EIT_MD_CARRIER       2'h1
`define EIT_MD_PWM           2'h2

// Clock select codes
`define EIT_CKS_DIV1         3'h0
`define EIT_CKS_DIV4         3'h1
`define EIT_CKS_DIV16        3'h2
`define EIT_CKS_DIV64        3'h3
`define EIT_CKS_DIV4096      3'h4
`define EIT_CKS_LS_DIV128    3'h5
`define EIT_CKS_LS_DIV512    3'h6
`define EIT_CKS_LS_DIV1      3'h7

// Prescaler tap positions (tap k gives divide by 2^(k+1))
`define EIT_TAP_DIV4         1
`define EIT_TAP_DIV16        3
`define EIT_TAP_DIV64        5
`define EIT_TAP_DIV128       6
`define EIT_TAP_DIV512       8
`define EIT_TAP_DIV4096      11
`define EIT_PRESC_W          12

// Port pin that carries the timer output
`define EIT_TIMER_PIN        6
`define EIT_ZERO8            8'h00
`define EIT_ONE8             8'h01

// Gate transfer delay stages, counted in count clocks
`define EIT_XFER_START       2'h1
`define EIT_XFER_LAST        2'h2

`endif

// file: logic/eit_count_clock.v
// Count clock enable selector with prescalers for both clock sources
`timescale 1ns/1ps
module eit_count_clock (
  input  wire       mclk,
  input  wire       reset_n,
  input  wire       lowSpeedTick,
  input  wire [2:0] clockSelect,
  output reg        countTick
);
`include "eit_consts.vh"

  reg  [`EIT_PRESC_W-1:0] perDiv_q;   // Peripheral clock prescaler
  reg  [`EIT_PRESC_W-1:0] lsDiv_q;    // Low-speed clock prescaler
  wire [`EIT_PRESC_W-1:0] perCarry;   // Peripheral carry-out taps
  wire [`EIT_PRESC_W-1:0] lsCarry;    // Low-speed carry-out taps
  reg                     tickSel;    // Selected enable

  // One carry tap per prescaler bit
  genvar k;
  generate
    for (k = 0; k < `EIT_PRESC_W; k = k + 1) begin : gTap
      assign perCarry[k] = &perDiv_q[k:0];
      assign lsCarry[k]  = lowSpeedTick & (&lsDiv_q[k:0]);
    end
  endgenerate

  // Free-running prescalers
  always @(posedge mclk) begin
    if (!reset_n) begin
      perDiv_q <= {`EIT_PRESC_W{1'b0}};
      lsDiv_q  <= {`EIT_PRESC_W{1'b0}};
    end else begin
      perDiv_q <= perDiv_q + 1'b1;
      if (lowSpeedTick) begin
        lsDiv_q <= lsDiv_q + 1'b1;
      end
    end
  end

  // Source and ratio selection
  always @* begin
    case (clockSelect)
      `EIT_CKS_DIV1:      tickSel = 1'b1;
      `EIT_CKS_DIV4:      tickSel = perCarry[`EIT_TAP_DIV4];
      `EIT_CKS_DIV16:     tickSel = perCarry[`EIT_TAP_DIV16];
      `EIT_CKS_DIV64:     tickSel = perCarry[`EIT_TAP_DIV64];
      `EIT_CKS_DIV4096:   tickSel = perCarry[`EIT_TAP_DIV4096];
      `EIT_CKS_LS_DIV128: tickSel = lsCarry[`EIT_TAP_DIV128];
      `EIT_CKS_LS_DIV512: tickSel = lsCarry[`EIT_TAP_DIV512];
      default:            tickSel = lowSpeedTick;
    endcase
  end

  // Registered enable pulse
  always @(posedge mclk) begin
    if (!reset_n) begin
      countTick <= 1'b0;
    end else begin
      countTick <= tickSel;
    end
  end

endmodule // eit_count_clock

// file: sim/eit_timer_properties.sv
// Assertion checker for the interval timer block
`timescale 1ns/1ps
module eit_timer_props (
  input logic        mclk,
  input logic        reset_n,
  input logic [15:0] regAddr,
  input logic [7:0]  regWrData,
  input logic        regWrite,
  input logic        regRead,
  input logic [7:0]  regRdData,
  input logic        matchInterrupt,
  input logic        timerOutputPin,
  input logic        timerPinOe,
  input logic [7:0]  portDirection
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [7:0] modeQ;  // Mode byte as held
  logic [7:0] perQ;   // Period compare as written
  logic [8:0] gapQ;   // Cycles since start or interrupt
  logic [1:0] quietQ; // Cycles since mode write
  logic       seenQ;  // Interrupt seen in this run
  wire wrMode = regWrite && regAddr == 16'hff6c;
  wire fastInt = modeQ[7] && modeQ[6:2] == 5'h00;
  // Shadow of software writes
  always @(posedge mclk) begin
    if (!reset_n) begin
      modeQ <= 8'h00;
      perQ <= 8'h00;
      gapQ <= 9'h000;
      quietQ <= 2'h0;
      seenQ <= 1'b0;
    end else begin
      // Running: only the run bit moves
      if (wrMode)
        modeQ <= modeQ[7] ? {regWrData[7], modeQ[6:0]} : regWrData;
      if (regWrite && regAddr == 16'hff1a)
        perQ <= regWrData;
      quietQ <= wrMode ? 2'h0 : quietQ + {1'b0, quietQ != 2'h3};
      seenQ <= modeQ[7] && (seenQ || matchInterrupt);
      gapQ <= (matchInterrupt || (wrMode && !modeQ[7])) ? 9'h001
                                                         : gapQ + 9'h001;
    end
  end
  a_dir_write: assert property (
    regWrite && regAddr == 16'hff21 |=> portDirection == $past(regWrData))
    else $error("direction write lost");
  a_pin_drive: assert property (
    $stable(portDirection) |-> timerPinOe == !portDirection[6])
    else $error("pin enable wrong");
  a_mode_read: assert property (
    regRead && regAddr == 16'hff6c |=> regRdData == $past(modeQ))
    else $error("mode readback wrong");
  a_irq_single: assert property (
    matchInterrupt |=> !matchInterrupt)
    else $error("interrupt too long");
  a_first_match: assert property (
    fastInt && matchInterrupt && !seenQ |-> gapQ == {1'b0, perQ} + 9'h003)
    else $error("first match late");
  a_match_gap: assert property (
    fastInt && matchInterrupt && seenQ |-> gapQ == {1'b0, perQ} + 9'h001)
    else $error("match interval wrong");
  a_pin_toggle: assert property (
    matchInterrupt && modeQ[3:2] == 2'h0 && modeQ[0]
      |-> timerOutputPin != $past(timerOutputPin))
    else $error("pin did not toggle");
  a_pin_idle: assert property (
    quietQ == 2'h3 && modeQ[3:2] == 2'h0 && !(modeQ[7] && modeQ[0])
      |-> timerOutputPin == modeQ[1])
    else $error("pin not at idle level");
  a_stop_quiet: assert property (
    !modeQ[7] && quietQ == 2'h3 |-> !matchInterrupt)
    else $error("interrupt while stopped");
endmodule // eit_timer_props
bind eit_timer eit_timer_props uProps (
  .mclk(mclk), .reset_n(reset_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .matchInterrupt(matchInterrupt),
  .timerOutputPin(timerOutputPin), .timerPinOe(timerPinOe),
  .portDirection(portDirection)
);

// file: sim/tb_eit_timer.sv
// Self-checking bench for the interval timer block
`timescale 1ns/1ps
module tb_eit_timer;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic lowSpeedClk = 1'b0;
  logic companionMatch = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic rdSeen = 1'b0;  // Read answer due
  wire [7:0] regRdData;
  wire matchInterrupt;
  wire timerOutputPin;
  wire timerPinOe;
  wire remoteOutput;
  wire [7:0] portDirection;
  logic [7:0] exp [$];  // Expected read data
  logic [31:0] seed = 32'd54;
  int n_errors = 0;
  int total_checks = 0;
  // Divide in mclk cycles; low-speed clock is mclk/8
  int divTab [8] = '{1, 4, 16, 64, 4096, 1024, 4096, 8};
  always #2.5 mclk = ~mclk;
  always #20 lowSpeedClk = ~lowSpeedClk;
  eit_timer DUT (.mclk(mclk), .reset_n(reset_n),
    .lowSpeedClk(lowSpeedClk), .companionMatch(companionMatch),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData),
    .matchInterrupt(matchInterrupt), .timerOutputPin(timerOutputPin),
    .timerPinOe(timerPinOe), .remoteOutput(remoteOutput),
    .portDirection(portDirection));
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] want);
    total_checks++;
    if (got !== want) begin
      $display("Error t=%0t got %h exp %h", $time, got, want);
      n_errors++;
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    exp.push_back(e);
    @(posedge mclk);
    regRead <= 1'b0;
  endtask
  // Read results against the oldest note
  always @(posedge mclk) rdSeen <= regRead;
  always @(negedge mclk)
    if (rdSeen) chk(regRdData, exp.pop_front());
  // Bounded wait for the next interrupt
  task automatic wirq(output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (matchInterrupt !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    logic [7:0] m, per, x;
    logic p, rc, gb;
    int g, h;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    rd(16'hff21, 8'hff);
    rd(16'hff6c, 8'h00);
    rd(16'h0000, 8'h00);
    wr(16'hff6d, 8'hff);
    rd(16'hff6d, 8'h06);
    x = xs();
    for (int j = 0; j < 2; j++) begin
      wr(16'hff21, x);
      rd(16'hff21, x);
      @(negedge mclk);
      chk(timerPinOe, !x[6]);
      x ^= 8'h40;
    end
    wr(16'hff21, 8'hbf);
    $display("Register test done");
    for (int c = 0; c < 8; c++) begin
      x = xs();
      per = (c == 4 || c == 6) ? 8'h01 : {6'h00, x[1:0]} + 8'h01;
      m = {1'b0, c[2:0], 2'b00, c[0], c != 3};
      wr(16'hff1a, per);
      wr(16'hff6c, m);
      wr(16'hff6c, m | 8'h80);
      wirq(g);
      chk(timerOutputPin, m[1] ^ m[0]);
      if (c == 0) begin
        wr(16'hff6c, 8'hff);
        rd(16'hff6c, m | 8'h80);
      end
      wr(16'hff1b, xs());
      wirq(g);
      p = timerOutputPin;
      wirq(g);
      chk(g, (per + 1) * divTab[c]);
      chk(timerOutputPin, m[0] ? !p : m[1]);
      wr(16'hff6c, m);
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chk(matchInterrupt, 1'b0);
      chk(timerOutputPin, m[1]);
      $display("Interval test code %0d done", c);
    end
    wr(16'hff1a, 8'h03);
    wr(16'hff6c, 8'h05);
    wr(16'hff1b, 8'h03);
    wr(16'hff6c, 8'h85);
    for (int i = 0; i < 4; i++) begin
      rc = i[1];
      gb = i[1] == i[0];
      wr(16'hff6d, {5'h00, rc, gb, 1'b0});
      companionMatch <= 1'b1;
      repeat (4) @(posedge mclk);
      companionMatch <= 1'b0;
      repeat (8) @(posedge mclk);
      rd(16'hff6d, {5'h00, rc, gb, gb});
      // Count output edges; carrier toggles every four count clocks
      @(negedge mclk);
      p = remoteOutput;
      x[0] = timerOutputPin;
      g = 0;
      h = 0;
      repeat (16) begin
        @(negedge mclk);
        g += (remoteOutput != p);
        h += (timerOutputPin != x[0]);
        p = remoteOutput;
        x[0] = timerOutputPin;
      end
      chk(g, (rc && gb) ? 4 : 0);
      chk(h, (rc && gb) ? 4 : 0);
      if (!(rc && gb)) chk(remoteOutput, gb && !rc);
      if (!(rc && gb)) chk(timerOutputPin, gb && !rc);
    end
    wr(16'hff6c, 8'h05);
    $display("Carrier test done");
    repeat (4) @(posedge mclk);
    close_out();
  end
endmodule // tb_eit_timer
